// ===== pkg/mcfc_pkg.sv
// shared constants, selects and carriers for the microcore flow and counter registers
`default_nettype none
package mcfc_pkg;
  localparam int ADDR_W  = 10;   // return and jump register width
  localparam int WORD_W  = 16;   // data word width
  localparam int PP_W    = 16;   // program pointer width
  localparam int NUM_CNT = 4;    // counters per microcore
  localparam int FLAG_W  = 16;   // flag count
  localparam int CRAM_WORDS = 1023;
  localparam int DRAM_WORDS = 64;
  localparam int DRAM_AW    = 6;
  localparam int NUM_FREE   = 2;  // counters that tick every clock

  localparam logic [WORD_W-1:0] COUNT_MAX_DEF = 16'h0fff; // printed wrap point
  localparam logic [WORD_W-1:0] CNT_ZERO      = 16'h0000;
  localparam logic [WORD_W-1:0] CNT_RST       = 16'h0000;
  localparam logic [WORD_W-1:0] LIM_RST       = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAG_RST      = 16'hffff; // released flags do not dominate
  localparam logic [ADDR_W-1:0] ADDR_RST      = 10'h000;
  localparam logic [PP_W-1:0]   PP_RST        = 16'h0000;
  localparam logic [PP_W-1:0]   PP_STEP       = 16'h0001;
  localparam logic [WORD_W-1:0] CNT_STEP      = 16'h0001;

  // operand selects seen by the instruction decoder; the interrupt return register has none
  typedef enum logic [3:0] {
    MCFC_SEL_NONE  = 4'h0,
    MCFC_SEL_SUBRT = 4'h1,
    MCFC_SEL_JT1   = 4'h2,
    MCFC_SEL_JT2   = 4'h3,
    MCFC_SEL_TICK1 = 4'h4,
    MCFC_SEL_TICK2 = 4'h5,
    MCFC_SEL_TICK3 = 4'h6,
    MCFC_SEL_TICK4 = 4'h7,
    MCFC_SEL_LIM1  = 4'h8,
    MCFC_SEL_LIM2  = 4'h9,
    MCFC_SEL_LIM3  = 4'ha,
    MCFC_SEL_LIM4  = 4'hb,
    MCFC_SEL_FLAGS = 4'hc
  } mcfc_sel_t;

  // program flow events, one-cycle pulses from the sequencer
  typedef struct packed {
    logic              fetch;
    logic              irq_enter;
    logic              irq_return;
    logic              ret_to_entry;
    logic              call_sub;
    logic              ret_sub;
    logic              far_jump;
    logic              far_sel;     // 0 selects target one, 1 target two
  } mcfc_flow_t;

  // register write from copy or load style instructions
  typedef struct packed {
    logic              en;
    mcfc_sel_t         sel;
    logic [WORD_W-1:0] data;
  } mcfc_wr_t;

  // set-flag instruction
  typedef struct packed {
    logic              en;
    logic [3:0]        idx;
    logic              val;
  } mcfc_flag_t;
endpackage
`default_nettype wire

// ===== hw/mcfc_regs.sv
// per-microcore flow, counter, flag and memory resources
//
// Behaviour
// - interrupt entry saves program pointer, ten bits
// - interrupt return reloads pointer or entry point
// - interrupt return register hidden from operand selects
// - subroutine calls save following instruction address
// - subroutine return reloads pointer from saved address
// - subroutine return address readable by microcode
// - jump targets written by load instructions
// - far jump loads pointer from selected target
// - four private sixteen-bit counters per core
// - counter wraps to zero after maximum
// - counters one, two tick every clock
// - counters three, four tick on prescaler enable
// - counters writable and readable by instructions
// - counter equal limit raises flag, stops
// - terminal flags offered as wait conditions
// - count limits writable and readable
// - sixteen flags, AND across all cores
// - set-flag drives own bits, combined readable
// - code memory 1023 words sixteen bits
// - data memory 64 words sixteen bits
// - program pointer advances on fetch unless a jump, call, return or interrupt entry coincides
`timescale 1ns/1ps
`default_nettype none
module mcfc_regs #(
  parameter int                  NUM_CORES = 4,
  parameter logic [mcfc_pkg::WORD_W-1:0] COUNT_MAX = mcfc_pkg::COUNT_MAX_DEF
) (
  input  wire logic                                   clock,
  input  wire logic                                   rst,
  input  wire mcfc_pkg::mcfc_flow_t                   flow,
  input  wire logic [mcfc_pkg::ADDR_W-1:0]            call_target,
  input  wire logic [mcfc_pkg::ADDR_W-1:0]            irq_vector,
  input  wire logic [mcfc_pkg::ADDR_W-1:0]            entry_point,
  input  wire mcfc_pkg::mcfc_wr_t                     wr,
  input  wire mcfc_pkg::mcfc_sel_t                    rd_sel,
  input  wire logic                                   prescale_tick,
  input  wire mcfc_pkg::mcfc_flag_t                   flag_set,
  input  wire logic [(NUM_CORES-1)*mcfc_pkg::FLAG_W-1:0] flags_others,
  input  wire logic                                   cram_we,
  input  wire logic [mcfc_pkg::ADDR_W-1:0]            cram_addr,
  input  wire logic [mcfc_pkg::WORD_W-1:0]            cram_wdata,
  input  wire logic                                   dram_we,
  input  wire logic [mcfc_pkg::DRAM_AW-1:0]           dram_addr,
  input  wire logic [mcfc_pkg::WORD_W-1:0]            dram_wdata,
  output var  logic [mcfc_pkg::PP_W-1:0]              program_pointer_q,
  output var  logic [mcfc_pkg::WORD_W-1:0]            instr_q,
  output var  logic [mcfc_pkg::WORD_W-1:0]            dram_rdata_q,
  output var  logic [mcfc_pkg::WORD_W-1:0]            rd_data_q,
  output var  logic [mcfc_pkg::NUM_CNT-1:0]           tc_q,
  output var  logic [mcfc_pkg::FLAG_W-1:0]            flag_own_q,
  output var  logic [mcfc_pkg::FLAG_W-1:0]            flags_and_q
);

  localparam int AW = mcfc_pkg::ADDR_W;
  localparam int WW = mcfc_pkg::WORD_W;
  localparam int NC = mcfc_pkg::NUM_CNT;
  localparam int FW = mcfc_pkg::FLAG_W;

  // refuse settings the logic cannot serve, at elaboration
  if (NUM_CORES < 2)
  begin : g_few_cores
    $error("mcfc_regs: NUM_CORES must be at least 2");
  end
  if (COUNT_MAX == mcfc_pkg::CNT_ZERO)
  begin : g_zero_max
    $error("mcfc_regs: COUNT_MAX must be nonzero");
  end

  // widen a ten-bit address onto the program pointer
  function automatic logic [mcfc_pkg::PP_W-1:0] widen(input logic [AW-1:0] a);
    widen = {{(mcfc_pkg::PP_W-AW){1'b0}}, a};
  endfunction

  // next value of a counter, wrapping after the maximum
  function automatic logic [WW-1:0] bump(input logic [WW-1:0] c);
    bump = (c == COUNT_MAX) ? mcfc_pkg::CNT_ZERO : c + mcfc_pkg::CNT_STEP;
  endfunction

  logic [AW-1:0] irq_resume_q;
  logic [AW-1:0] subrt_q;
  logic [AW-1:0] jt1_q;
  logic [AW-1:0] jt2_q;
  logic [WW-1:0] cnt_q [NC];
  logic [WW-1:0] cnt_d [NC];
  logic [WW-1:0] lim_q [NC];
  logic [WW-1:0] lim_d [NC];
  logic [NC-1:0] eq;
  logic [NC-1:0] tick;
  logic [mcfc_pkg::PP_W-1:0] pp_d;
  logic [FW-1:0] flag_own_d;
  logic [FW-1:0] flags_all;
  logic [FW-1:0] others_and;
  logic [WW-1:0] rd_mux;
  logic [WW-1:0] cram [mcfc_pkg::CRAM_WORDS];
  logic [WW-1:0] dram [mcfc_pkg::DRAM_WORDS];

  // decoded write strobes
  wire wr_jt1   = wr.en && (wr.sel == mcfc_pkg::MCFC_SEL_JT1);
  wire wr_jt2   = wr.en && (wr.sel == mcfc_pkg::MCFC_SEL_JT2);
  wire wr_flags = wr.en && (wr.sel == mcfc_pkg::MCFC_SEL_FLAGS);
  wire [AW-1:0] pp_lo = program_pointer_q[AW-1:0];
  wire [AW-1:0] far_dest = flow.far_sel ? jt2_q : jt1_q;

  // program pointer: returns and jumps take priority over plain fetch advance
  always_comb
  begin
    pp_d = program_pointer_q;
    if (flow.irq_return)
      pp_d = flow.ret_to_entry ? widen(entry_point) : widen(irq_resume_q);
    else if (flow.ret_sub)
      pp_d = widen(subrt_q);
    else if (flow.far_jump)
      pp_d = widen(far_dest);
    else if (flow.call_sub)
      pp_d = widen(call_target);
    else if (flow.irq_enter)
      pp_d = widen(irq_vector);
    else if (flow.fetch)
      pp_d = program_pointer_q + mcfc_pkg::PP_STEP;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      program_pointer_q <= mcfc_pkg::PP_RST;
    else
      program_pointer_q <= pp_d;
  end

  // return registers are loaded only by the flow mechanism, never by operand writes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irq_resume_q <= mcfc_pkg::ADDR_RST;
      subrt_q <= mcfc_pkg::ADDR_RST;
    end
    else
    begin
      if (flow.irq_enter)
        irq_resume_q <= pp_lo;
      if (flow.call_sub)
        subrt_q <= pp_lo;  // pointer already holds the following address
    end
  end

  // jump targets
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      jt1_q <= mcfc_pkg::ADDR_RST;
      jt2_q <= mcfc_pkg::ADDR_RST;
    end
    else
    begin
      if (wr_jt1)
        jt1_q <= wr.data[AW-1:0];
      if (wr_jt2)
        jt2_q <= wr.data[AW-1:0];
    end
  end

  // counters: a write wins over the tick; a match freezes the count until a write breaks it
  always_comb
  begin
    for (int i = 0; i < NC; i++)
    begin
      eq[i]    = (cnt_q[i] == lim_q[i]);
      tick[i]  = (i < mcfc_pkg::NUM_FREE) ? 1'b1 : prescale_tick;
      cnt_d[i] = cnt_q[i];
      lim_d[i] = lim_q[i];
      if (wr.en && (wr.sel == mcfc_pkg::mcfc_sel_t'(mcfc_pkg::MCFC_SEL_TICK1 + i)))
        cnt_d[i] = wr.data;
      else if (tick[i] && !eq[i])
        cnt_d[i] = bump(cnt_q[i]);
      if (wr.en && (wr.sel == mcfc_pkg::mcfc_sel_t'(mcfc_pkg::MCFC_SEL_LIM1 + i)))
        lim_d[i] = wr.data;
    end
  end

  // four private counter and limit pairs; terminal flags follow the stored pair exactly
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NC; i++)
    begin
      if (rst)
      begin
        cnt_q[i] <= mcfc_pkg::CNT_RST;
        lim_q[i] <= mcfc_pkg::LIM_RST;
        tc_q[i]  <= (mcfc_pkg::CNT_RST == mcfc_pkg::LIM_RST);
      end
      else
      begin
        cnt_q[i] <= cnt_d[i];
        lim_q[i] <= lim_d[i];
        tc_q[i]  <= (cnt_d[i] == lim_d[i]);  // wait-table condition
      end
    end
  end

  // own flag contribution: word write, then single-bit set-flag on top
  always_comb
  begin
    flag_own_d = wr_flags ? wr.data : flag_own_q;
    if (flag_set.en)
      flag_own_d[flag_set.idx] = flag_set.val;
  end

  // a zero from any core dominates the visible flag word
  // the other cores are folded first so the check below can see their combined word
  always_comb
  begin
    others_and = '1;
    for (int k = 0; k < NUM_CORES - 1; k++)
      others_and = others_and & flags_others[k*FW +: FW];
    flags_all = flag_own_d & others_and;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flag_own_q  <= mcfc_pkg::FLAG_RST;
      flags_and_q <= mcfc_pkg::FLAG_RST;
    end
    else
    begin
      flag_own_q  <= flag_own_d;
      flags_and_q <= flags_all;
    end
  end

  // operand read mux; jump targets are write-only and the interrupt return has no select
  assign rd_mux =
    (rd_sel == mcfc_pkg::MCFC_SEL_SUBRT) ? {{(WW-AW){1'b0}}, subrt_q} :
    (rd_sel == mcfc_pkg::MCFC_SEL_TICK1) ? cnt_q[0] :
    (rd_sel == mcfc_pkg::MCFC_SEL_TICK2) ? cnt_q[1] :
    (rd_sel == mcfc_pkg::MCFC_SEL_TICK3) ? cnt_q[2] :
    (rd_sel == mcfc_pkg::MCFC_SEL_TICK4) ? cnt_q[3] :
    (rd_sel == mcfc_pkg::MCFC_SEL_LIM1)  ? lim_q[0] :
    (rd_sel == mcfc_pkg::MCFC_SEL_LIM2)  ? lim_q[1] :
    (rd_sel == mcfc_pkg::MCFC_SEL_LIM3)  ? lim_q[2] :
    (rd_sel == mcfc_pkg::MCFC_SEL_LIM4)  ? lim_q[3] :
    (rd_sel == mcfc_pkg::MCFC_SEL_FLAGS) ? flags_and_q :
    mcfc_pkg::CNT_ZERO;

  always_ff @(posedge clock)
  begin
    if (rst)
      rd_data_q <= mcfc_pkg::CNT_ZERO;
    else
      rd_data_q <= rd_mux;
  end

  // memories have no reset; the last code address has no word and reads zero
  wire cram_hit = (32'(cram_addr) < mcfc_pkg::CRAM_WORDS);
  wire pp_hit   = (32'(pp_lo) < mcfc_pkg::CRAM_WORDS);

  always_ff @(posedge clock)
  begin
    if (cram_we && cram_hit)
      cram[cram_addr] <= cram_wdata;
    if (dram_we)
      dram[dram_addr] <= dram_wdata;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      instr_q      <= mcfc_pkg::CNT_ZERO;
      dram_rdata_q <= mcfc_pkg::CNT_ZERO;
    end
    else
    begin
      instr_q      <= pp_hit ? cram[pp_lo] : mcfc_pkg::CNT_ZERO;
      dram_rdata_q <= dram[dram_addr];
    end
  end

  // checks
  irq_capture_a: assert property (@(posedge clock) disable iff (rst)
    flow.irq_enter |=> irq_resume_q == $past(pp_lo))
    else $error("interrupt return did not capture pointer");

  irq_return_a: assert property (@(posedge clock) disable iff (rst)
    flow.irq_return && !flow.ret_to_entry |=> program_pointer_q == widen($past(irq_resume_q)))
    else $error("interrupt return did not reload pointer");

  entry_return_a: assert property (@(posedge clock) disable iff (rst)
    flow.irq_return && flow.ret_to_entry |=> program_pointer_q == widen($past(entry_point)))
    else $error("interrupt return did not take entry point");

  subrt_store_a: assert property (@(posedge clock) disable iff (rst)
    flow.call_sub ##1 (!flow.call_sub)[*2] |-> subrt_q == $past(pp_lo, 2))
    else $error("subroutine return address lost");

  sub_return_a: assert property (@(posedge clock) disable iff (rst)
    flow.ret_sub && !flow.irq_return |=> program_pointer_q == widen($past(subrt_q)))
    else $error("subroutine return did not reload pointer");

  jt_load_a: assert property (@(posedge clock) disable iff (rst)
    wr_jt2 |=> jt2_q == $past(wr.data[AW-1:0]))
    else $error("jump target two not loaded");

  far_jump_a: assert property (@(posedge clock) disable iff (rst)
    flow.far_jump && !flow.irq_return && !flow.ret_sub |=> program_pointer_q == widen($past(far_dest)))
    else $error("far jump went to wrong address");

  free_tick_a: assert property (@(posedge clock) disable iff (rst)
    !eq[0] && !(wr.en && wr.sel == mcfc_pkg::MCFC_SEL_TICK1) |=> cnt_q[0] == bump($past(cnt_q[0])))
    else $error("counter one did not advance");

  presc_hold_a: assert property (@(posedge clock) disable iff (rst)
    !prescale_tick && !(wr.en && wr.sel == mcfc_pkg::MCFC_SEL_TICK3) |=> $stable(cnt_q[2]))
    else $error("counter three moved without enable");

  count_stop_a: assert property (@(posedge clock) disable iff (rst)
    eq[1] && !(wr.en && (wr.sel == mcfc_pkg::MCFC_SEL_TICK2 || wr.sel == mcfc_pkg::MCFC_SEL_LIM2))
    |=> $stable(cnt_q[1]) && tc_q[1])
    else $error("counter two did not stop at limit");

  tc_match_a: assert property (@(posedge clock) disable iff (rst)
    tc_q == eq)
    else $error("terminal flags disagree with compare");

  flag_and_a: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> flags_and_q == (flag_own_q & $past(others_and)))
    else $error("visible flags are not the AND of all cores");

  flag_set_a: assert property (@(posedge clock) disable iff (rst)
    flag_set.en |=> flag_own_q[$past(flag_set.idx)] == $past(flag_set.val))
    else $error("set-flag not applied");

  fetch_step_a: assert property (@(posedge clock) disable iff (rst)
    flow.fetch && !flow.irq_return && !flow.ret_sub && !flow.far_jump && !flow.call_sub && !flow.irq_enter
    |=> program_pointer_q == $past(program_pointer_q) + mcfc_pkg::PP_STEP)
    else $error("fetch did not advance pointer");

  // wrap point, operand writes and reads, and resume after a limit write
  wrap_point_a: assert property (@(posedge clock) disable iff (rst)
    cnt_q[1] == COUNT_MAX && !eq[1] && !(wr.en && wr.sel == mcfc_pkg::MCFC_SEL_TICK2)
    |=> cnt_q[1] == mcfc_pkg::CNT_ZERO)
    else $error("counter two did not wrap to zero");

  cnt_write_a: assert property (@(posedge clock) disable iff (rst)
    wr.en && wr.sel == mcfc_pkg::MCFC_SEL_TICK1 |=> cnt_q[0] == $past(wr.data))
    else $error("counter one write not taken");

  lim_write_a: assert property (@(posedge clock) disable iff (rst)
    wr.en && wr.sel == mcfc_pkg::MCFC_SEL_LIM3 |=> lim_q[2] == $past(wr.data))
    else $error("limit three write not taken");

  subrt_read_a: assert property (@(posedge clock) disable iff (rst)
    rd_sel == mcfc_pkg::MCFC_SEL_SUBRT |=> rd_data_q == {{(WW-AW){1'b0}}, $past(subrt_q)})
    else $error("subroutine return address not readable");

  hidden_read_a: assert property (@(posedge clock) disable iff (rst)
    rd_sel > mcfc_pkg::MCFC_SEL_FLAGS |=> rd_data_q == mcfc_pkg::CNT_ZERO)
    else $error("unmapped select returned data");

  count_resume_a: assert property (@(posedge clock) disable iff (rst)
    tc_q[0] && wr.en && wr.sel == mcfc_pkg::MCFC_SEL_LIM1 && wr.data != cnt_q[0] |=> !tc_q[0])
    else $error("limit write did not clear terminal flag");

endmodule
`default_nettype wire

// ===== verification/mcfc_regs_tb_top.sv
// self-checking testbench for the microcore flow, counter and flag registers
`timescale 1ns/1ps
`default_nettype none
module mcfc_regs_tb_top;
  localparam logic [15:0] CMAX = mcfc_pkg::COUNT_MAX_DEF;
  logic                      clock;
  logic                      rst;
  mcfc_pkg::mcfc_flow_t      flow;
  logic [9:0]                call_target;
  logic [9:0]                irq_vector;
  logic [9:0]                entry_point;
  mcfc_pkg::mcfc_wr_t        wr;
  mcfc_pkg::mcfc_sel_t       rd_sel;
  logic                      prescale_tick;
  mcfc_pkg::mcfc_flag_t      flag_set;
  logic [47:0]               flags_others;
  logic                      cram_we;
  logic [9:0]                cram_addr;
  logic [15:0]               cram_wdata;
  logic                      dram_we;
  logic [5:0]                dram_addr;
  logic [15:0]               dram_wdata;
  logic [15:0]               program_pointer_q;
  logic [15:0]               instr_q;
  logic [15:0]               dram_rdata_q;
  logic [15:0]               rd_data_q;
  logic [3:0]                tc_q;
  logic [15:0]               flag_own_q;
  logic [15:0]               flags_and_q;
  int                        bad_count;
  int                        total_checks;

  mcfc_regs #(.NUM_CORES(4), .COUNT_MAX(CMAX)) u_mcfc_regs (
    .clock(clock), .rst(rst), .flow(flow), .call_target(call_target), .irq_vector(irq_vector),
    .entry_point(entry_point), .wr(wr), .rd_sel(rd_sel), .prescale_tick(prescale_tick),
    .flag_set(flag_set), .flags_others(flags_others), .cram_we(cram_we), .cram_addr(cram_addr),
    .cram_wdata(cram_wdata), .dram_we(dram_we), .dram_addr(dram_addr), .dram_wdata(dram_wdata),
    .program_pointer_q(program_pointer_q), .instr_q(instr_q), .dram_rdata_q(dram_rdata_q),
    .rd_data_q(rd_data_q), .tc_q(tc_q), .flag_own_q(flag_own_q), .flags_and_q(flags_and_q)
  );

  // 125 MHz clock
  always #4 clock = ~clock;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // operand write: one-cycle enable, launched at the falling edge
  task automatic wreg(input logic [3:0] s, input logic [15:0] d);
    wr = '{en: 1'b1, sel: mcfc_pkg::mcfc_sel_t'(s), data: d};
    tick(1);
    wr.en = 1'b0;
  endtask

  // operand read: rd_data_q carries the select of the previous edge
  task automatic rreg(input logic [3:0] s, input logic [15:0] exp, input string name);
    rd_sel = mcfc_pkg::mcfc_sel_t'(s);
    tick(1);
    check(name, rd_data_q, exp);
  endtask

  // flow event held for n clocks, then released
  task automatic pulse(input logic [7:0] bits, input int n);
    flow = mcfc_pkg::mcfc_flow_t'(bits);
    tick(n);
    flow = '0;
  endtask

  // bounded wait for a terminal-count bit; running out ends the run
  task automatic wait_tc(input int i, input int lim);
    int n;
    n = 0;
    while (tc_q[i] !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
    begin
      check("tc wait", {15'h0, tc_q[i]}, 16'h0001);
      print_verdict();
    end
  endtask

  // watchdog so a hang still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    clock = 1'b0; rst = 1'b1; flow = '0; wr = '0; rd_sel = mcfc_pkg::MCFC_SEL_NONE;
    call_target = 10'h100; irq_vector = 10'h3c0; entry_point = 10'h020; prescale_tick = 1'b0;
    flag_set = '0; flags_others = '1; cram_we = 1'b0; cram_addr = 10'h000; cram_wdata = 16'h0000;
    dram_we = 1'b0; dram_addr = 6'h00; dram_wdata = 16'h0000; bad_count = 0; total_checks = 0;
    tick(12);
    rst = 1'b0;
    // reset state: stopped counters match zero limits, flags released
    check("pp", program_pointer_q, 16'h0000);
    check("tc", {12'h000, tc_q}, 16'h000f);
    check("flags", flags_and_q, 16'hffff);
    rreg(4'h4, 16'h0000, "tick1");
    // counter one resumes after a limit write, stops on the limit
    wreg(4'h8, 16'h0010);
    check("tc1 clear", {15'h0, tc_q[0]}, 16'h0000);
    wait_tc(0, 40);
    rreg(4'h4, 16'h0010, "tick1 stop");
    tick(5);
    rreg(4'h4, 16'h0010, "tick1 held");
    rreg(4'h8, 16'h0010, "lim1");
    wreg(4'h4, 16'h0020);
    tick(2);
    check("tc1 resume", {15'h0, tc_q[0]}, 16'h0000);
    wreg(4'h4, 16'h0010);
    check("tc1 set", {15'h0, tc_q[0]}, 16'h0001);
    // counter two wraps past the maximum and stops on a small limit
    wreg(4'h9, 16'h0005);
    wreg(4'h5, CMAX - 16'h0001);
    wait_tc(1, 20);
    rreg(4'h5, 16'h0005, "tick2 wrap");
    // counters three and four move only on prescaler ticks
    wreg(4'ha, 16'h0003);
    wreg(4'hb, 16'h0002);
    tick(5);
    rreg(4'h6, 16'h0000, "tick3 idle");
    prescale_tick = 1'b1;
    tick(3);
    prescale_tick = 1'b0;
    tick(1);
    check("tc34", {14'h0, tc_q[3:2]}, 16'h0003);
    rreg(4'h6, 16'h0003, "tick3");
    rreg(4'h7, 16'h0002, "tick4");
    // code word placed where the far jump lands
    cram_we = 1'b1; cram_addr = 10'h155; cram_wdata = 16'h1234;
    tick(1);
    cram_we = 1'b0;
    // jump targets keep ten bits and are write-only
    wreg(4'h2, 16'hfd55);
    wreg(4'h3, 16'h02aa);
    rreg(4'h2, 16'h0000, "jt1 wo");
    pulse(8'h03, 1);
    check("far jt2", program_pointer_q, 16'h02aa);
    pulse(8'h02, 1);
    check("far jt1", program_pointer_q, 16'h0155);
    tick(1);
    check("instr", instr_q, 16'h1234);
    pulse(8'h80, 3);
    check("fetch", program_pointer_q, 16'h0158);
    // subroutine call saves the return address, return restores it
    pulse(8'h08, 1);
    check("call", program_pointer_q, 16'h0100);
    wreg(4'h1, 16'h0000);
    rreg(4'h1, 16'h0158, "subrt");
    pulse(8'h04, 1);
    check("ret", program_pointer_q, 16'h0158);
    // interrupt entry, plain return, then return to the entry point
    pulse(8'h40, 1);
    check("irq", program_pointer_q, 16'h03c0);
    pulse(8'h80, 2);
    pulse(8'h20, 1);
    check("irq resume", program_pointer_q, 16'h0158);
    pulse(8'h40, 1);
    pulse(8'h30, 1);
    check("ientry", program_pointer_q, 16'h0020);
    // no operand select reaches the interrupt return register
    for (int i = 13; i < 16; i++)
      rreg(i[3:0], 16'h0000, "unmapped");
    // flags: own word, single-bit set, and another core pulling low
    wreg(4'hc, 16'hff0f);
    flag_set = '{en: 1'b1, idx: 4'h8, val: 1'b0};
    flags_others[17] = 1'b0;
    tick(1);
    flag_set.en = 1'b0;
    tick(2);
    check("flag own", flag_own_q, 16'hfe0f);
    check("flag and", flags_and_q, 16'hfe0d);
    rreg(4'hc, 16'hfe0d, "flag rd");
    // data memory write then read back
    dram_we = 1'b1; dram_addr = 6'h3f; dram_wdata = 16'h5a5a;
    tick(1);
    dram_we = 1'b0;
    tick(1);
    check("dram", dram_rdata_q, 16'h5a5a);
    print_verdict();
  end
endmodule
`default_nettype wire
